// *** ptsd_timebase.sv ***
/*
 * Time base sync select, special event postscaler and dead-time regs.
 * Assumes an APB master on pclk; sync inputs are asynchronous pins.
 */
// The register offsets and the APB slave port were decided locally.
// Function
// R1: Code 000 selects external sync input
// R2: Codes 010/011 select generator outputs 16/17
// R3: Postscaler 1111 triggers every sixteenth match
// R4: Code 0000 triggers every match (1:1)
// R5: Software changes fields only when disabled
// R6: Software sets period above sync period
// R7: Dead-time holds 14 RW bits, upper zero
// R8: Dead-time is unsigned count to unit
// R9: Trigger one cycle; count clears when disabled
`timescale 1ns/10ps
`default_nettype none
module ptsd_timebase
   import ptsd_pkg::*;
#(
   parameter int NUM_CH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ptsd_sync_in_t sync_in,
   input wire logic compare_match,
   output logic time_base_sync,
   output logic special_trigger,
   output logic time_base_enable,
   output logic [NUM_CH*PTSD_DT_W-1:0] dead_time
);
   ptsd_ctrl_t ctrl_r;
   ptsd_ctrl_t ctrl_nxt;
   logic [PTSD_DT_W-1:0] dt_r [NUM_CH];
   logic [PTSD_DT_W-1:0] dt_nxt [NUM_CH];
   logic [2:0] s1_r, s2_r, s3_r;
   logic [2:0] sv_r, sv_nxt;
   logic sync_sel;
   logic sync_d_r;
   logic sync_p_r, sync_p_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic wr_en, rd_en, hit;
   logic [PTSD_PS_W-1:0] ps_count;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Address decode
   always_comb begin
      hit = (paddr == PTSD_OFS_CTRL) || (paddr == PTSD_OFS_STAT);
      for (int i = 0; i < NUM_CH; i++) begin
         if (paddr == PTSD_OFS_DT0 + 8'(i * PTSD_CH_STRIDE)) begin
            hit = 1'b1;
         end
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   // Register writes
   always_comb begin
      ctrl_nxt = ctrl_r;
      for (int i = 0; i < NUM_CH; i++) begin
         dt_nxt[i] = dt_r[i];
      end
      if (wr_en && paddr == PTSD_OFS_CTRL) begin
         ctrl_nxt.time_base_enable = pwdata[PTSD_EN_BIT];
         ctrl_nxt.sync_source_select =
            ptsd_src_t'(pwdata[PTSD_SRC_LSB +: PTSD_SRC_W]);
         ctrl_nxt.special_trigger_postscale =
            pwdata[PTSD_PS_LSB +: PTSD_PS_W];
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (wr_en && paddr == PTSD_OFS_DT0 + 8'(i * PTSD_CH_STRIDE)) begin
            dt_nxt[i] = pwdata[PTSD_DT_W-1:0]; // R7
         end
      end
   end

   // Read data
   always_comb begin
      rd_nxt = rd_r;
      if (rd_en) begin
         rd_nxt = 32'h0000_0000;
         if (paddr == PTSD_OFS_CTRL) begin
            rd_nxt[PTSD_EN_BIT] = ctrl_r.time_base_enable;
            rd_nxt[PTSD_SRC_LSB +: PTSD_SRC_W] = ctrl_r.sync_source_select;
            rd_nxt[PTSD_PS_LSB +: PTSD_PS_W] =
               ctrl_r.special_trigger_postscale;
         end else if (paddr == PTSD_OFS_STAT) begin
            rd_nxt[PTSD_PS_LSB +: PTSD_PS_W] = ps_count;
            rd_nxt[PTSD_SRC_LSB +: PTSD_SRC_W] = sv_r;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (paddr == PTSD_OFS_DT0 + 8'(i * PTSD_CH_STRIDE)) begin
               rd_nxt[PTSD_DT_W-1:0] = dt_r[i]; // R7
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r.time_base_enable <= PTSD_CTRL_RST[PTSD_EN_BIT];
         ctrl_r.sync_source_select <=
            ptsd_src_t'(PTSD_CTRL_RST[PTSD_SRC_LSB +: PTSD_SRC_W]);
         ctrl_r.special_trigger_postscale <=
            PTSD_CTRL_RST[PTSD_PS_LSB +: PTSD_PS_W];
         rd_r <= 32'h0000_0000;
         for (int i = 0; i < NUM_CH; i++) begin
            dt_r[i] <= PTSD_DT_RST; // R7
         end
      end else begin
         ctrl_r <= ctrl_nxt;
         rd_r <= rd_nxt;
         for (int i = 0; i < NUM_CH; i++) begin
            dt_r[i] <= dt_nxt[i];
         end
      end
   end

   assign prdata = rd_r;

   // Sync input synchronisers, three stages; stages 2 and 3 agree
   always_comb begin
      sv_nxt = sv_r;
      for (int b = 0; b < 3; b++) begin
         if (s2_r[b] == s3_r[b]) begin
            sv_nxt[b] = s3_r[b];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         s3_r <= 3'h0;
         sv_r <= 3'h0;
      end else begin
         s1_r <= sync_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         sv_r <= sv_nxt;
      end
   end

   // Source select; bit 2 external, 1 output 16, 0 output 17
   always_comb begin
      unique case (ctrl_r.sync_source_select)
         PTSD_SRC_EXT: sync_sel = sv_r[2]; // R1
         PTSD_SRC_TG16: sync_sel = sv_r[1]; // R2
         PTSD_SRC_TG17: sync_sel = sv_r[0]; // R2
         default: sync_sel = 1'b0; // R2
      endcase
   end

   always_comb begin
      sync_p_nxt = ctrl_r.time_base_enable && sync_sel && !sync_d_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_d_r <= 1'b0;
         sync_p_r <= 1'b0;
      end else begin
         sync_d_r <= sync_sel;
         sync_p_r <= sync_p_nxt; // R1
      end
   end

   assign time_base_sync = sync_p_r;
   assign time_base_enable = ctrl_r.time_base_enable;

   // Dead-time values as unsigned counts, one per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_dt
         assign dead_time[g*PTSD_DT_W +: PTSD_DT_W] = dt_r[g]; // R8
      end
   endgenerate

   ptsd_postscale #(
      .PS_W(PTSD_PS_W)
   ) u_post (
      .pclk(pclk),
      .presetn(presetn),
      .enable(ctrl_r.time_base_enable),
      .ratio(ctrl_r.special_trigger_postscale),
      .compare_match(compare_match),
      .trigger(special_trigger),
      .count(ps_count)
   );

   a_ext_sync_path: assert property (@(posedge pclk) // R1
      disable iff (!presetn)
      ctrl_r.time_base_enable && ctrl_r.sync_source_select == PTSD_SRC_EXT
      && sv_r[2] && !sync_d_r |=> time_base_sync)
      else $error("external sync lost");
   a_rsv_no_sync: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      ctrl_r.sync_source_select == PTSD_SRC_RSV1 && $stable(ctrl_r)
      |=> !time_base_sync) else $error("reserved code synced");
   a_tg16_sync: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      ctrl_r.time_base_enable && ctrl_r.sync_source_select == PTSD_SRC_TG16
      && sv_r[1] && !sync_d_r |=> time_base_sync)
      else $error("output 16 sync lost");
   a_tg17_sync: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      ctrl_r.time_base_enable && ctrl_r.sync_source_select == PTSD_SRC_TG17
      && sv_r[0] && !sync_d_r |=> time_base_sync)
      else $error("output 17 sync lost");
   a_dt_write: assert property (@(posedge pclk) // R7
      disable iff (!presetn)
      wr_en && paddr == PTSD_OFS_DT0 |=> dt_r[0] == $past(pwdata[13:0]))
      else $error("dead-time write lost");
   a_dt_out: assert property (@(posedge pclk) // R8
      disable iff (!presetn)
      wr_en && paddr == PTSD_OFS_DT0
      |=> dead_time[PTSD_DT_W-1:0] == $past(pwdata[PTSD_DT_W-1:0]))
      else $error("dead-time output mismatch");
   c_ext_sync: cover property (@(posedge pclk) disable iff (!presetn)
      time_base_sync && ctrl_r.sync_source_select == PTSD_SRC_EXT);
   c_tg17_sync: cover property (@(posedge pclk) disable iff (!presetn)
      time_base_sync && ctrl_r.sync_source_select == PTSD_SRC_TG17);
endmodule : ptsd_timebase
`default_nettype wire

// *** ptsd_pkg.sv ***
/*
 * Package for the PWM time base sync select, special event postscaler
 * and per-channel dead-time register block.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package ptsd_pkg;
   // Register byte offsets
   localparam logic [7:0] PTSD_OFS_CTRL = 8'h00;
   localparam logic [7:0] PTSD_OFS_STAT = 8'h04;
   localparam logic [7:0] PTSD_OFS_DT0 = 8'h10;
   localparam int PTSD_CH_STRIDE = 4;
   // Control field positions
   localparam int PTSD_EN_BIT = 15;
   localparam int PTSD_SRC_LSB = 4;
   localparam int PTSD_SRC_W = 3;
   localparam int PTSD_PS_LSB = 0;
   localparam int PTSD_PS_W = 4;
   localparam int PTSD_DT_W = 14;
   localparam logic [15:0] PTSD_CTRL_RST = 16'h0000;
   localparam logic [13:0] PTSD_DT_RST = 14'h0000;

   typedef enum logic [2:0] {
      PTSD_SRC_EXT = 3'h0,
      PTSD_SRC_RSV1 = 3'h1,
      PTSD_SRC_TG16 = 3'h2,
      PTSD_SRC_TG17 = 3'h3,
      PTSD_SRC_RSV4 = 3'h4,
      PTSD_SRC_RSV5 = 3'h5,
      PTSD_SRC_RSV6 = 3'h6,
      PTSD_SRC_RSV7 = 3'h7
   } ptsd_src_t;

   typedef struct packed {
      logic time_base_enable;
      ptsd_src_t sync_source_select;
      logic [3:0] special_trigger_postscale;
   } ptsd_ctrl_t;

   typedef struct packed {
      logic external_sync_input;
      logic trigger_gen_output_16;
      logic trigger_gen_output_17;
   } ptsd_sync_in_t;
endpackage : ptsd_pkg

// *** ptsd_postscale.sv ***
/*
 * Special event trigger postscaler.
 * Assumes compare match pulses synchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsd_postscale
   import ptsd_pkg::*;
#(
   parameter int PS_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [PS_W-1:0] ratio,
   input wire logic compare_match,
   output logic trigger,
   output logic [PS_W-1:0] count
);
   logic [PS_W-1:0] cnt_r;
   logic [PS_W-1:0] cnt_nxt;
   logic trig_r;
   logic trig_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      trig_nxt = 1'b0;
      if (!enable) begin
         cnt_nxt = '0; // R9
      end else if (compare_match) begin
         if (cnt_r >= ratio) begin // R4
            cnt_nxt = '0; // R3
            trig_nxt = 1'b1; // R9
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         trig_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         trig_r <= trig_nxt;
      end
   end

   assign trigger = trig_r;
   assign count = cnt_r;

   a_trig_one_cycle: assert property (@(posedge pclk) // R9
      disable iff (!presetn) trig_r |=> !trig_r)
      else $error("trigger wider than one cycle");
   a_cnt_clear_off: assert property (@(posedge pclk) // R9
      disable iff (!presetn) !enable |=> cnt_r == '0)
      else $error("count not cleared");
   a_trig_at_ratio: assert property (@(posedge pclk) // R3
      disable iff (!presetn)
      enable && compare_match && cnt_r == ratio |=> trig_r)
      else $error("missed trigger");
   a_no_trig_early: assert property (@(posedge pclk) // R4
      disable iff (!presetn)
      $rose(trig_r) |-> $past(cnt_r) == $past(ratio))
      else $error("early trigger");
   c_trig_max: cover property (@(posedge pclk) disable iff (!presetn)
      trig_r && ratio == 4'hf);
   c_trig_min: cover property (@(posedge pclk) disable iff (!presetn)
      trig_r && ratio == 4'h0);
endmodule : ptsd_postscale
`default_nettype wire

// *** ptsd_far_model.sv ***
/*
 * Far side model: sync pins and compare match source.
 * Assumes the bench requests pin levels and match pulses on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module ptsd_far_model
   import ptsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic match_req,
   input wire logic [2:0] pin_req,
   output ptsd_sync_in_t sync_in,
   output logic compare_match
);
   // Pins and match pulse launched one edge after request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_in <= '0;
         compare_match <= 1'b0;
      end else begin
         sync_in <= pin_req;
         compare_match <= match_req;
      end
   end
endmodule : ptsd_far_model
`default_nettype wire

// *** tb_pwm_timebase_sync_trigger_deadtime.sv ***
/*
 * Self-checking bench for the sync select, postscaler and dead-time block.
 * Assumes the zero-wait APB slave and offsets of the package.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_timebase_sync_trigger_deadtime
   import ptsd_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, e, mreq = 0, tbs, trig, ten;
   logic [2:0] pins = '0;
   ptsd_sync_in_t sync_in;
   logic cm;
   logic [41:0] dt;
   int failures = 0, total_checks = 0, tn = 0, sn = 0, t0, i;
   logic [7:0] ra[5] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h40};
   logic [31:0] rw[5] = '{32'hffff, 32'hffff, 32'h1234, 32'hc001, 32'h55};
   logic [31:0] rx[5] = '{32'h807f, 32'h3fff, 32'h1234, 32'h1, 32'h0};
   logic [2:0] sc[4] = '{3'h0, 3'h2, 3'h3, 3'h1};
   logic [2:0] sp[4] = '{3'h4, 3'h2, 3'h1, 3'h7};
   int sx[4] = '{1, 1, 1, 0};

   always #50 pclk = ~pclk;

   ptsd_timebase dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_in(sync_in), .compare_match(cm), .time_base_sync(tbs),
      .special_trigger(trig), .time_base_enable(ten), .dead_time(dt));

   ptsd_far_model far_u (.pclk(pclk), .presetn(presetn), .match_req(mreq),
      .pin_req(pins), .sync_in(sync_in), .compare_match(cm));

   always @(posedge pclk) begin
      if (trig === 1'b1) tn <= tn + 1;
      if (tbs === 1'b1) sn <= sn + 1;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         failures++;
         $display("[ERR] %s exp %h seen %h", n, x, s);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task mt(input int n);
      repeat (n) begin
         mreq <= 1'b1;
         @(posedge pclk);
         mreq <= 1'b0;
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask : mt

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PTSD_OFS_DT0, 32'h0);
      chk("dt0 reset", q, 32'h0);
      $display("reset test done");
      for (i = 0; i < 5; i++) begin
         apb(1'b1, ra[i], rw[i]);
         apb(1'b0, ra[i], 32'h0);
         chk("reg read", q, rx[i]);
         chk("slverr", {31'h0, e}, {31'h0, ra[i] == 8'h40});
      end
      chk("dead_time 0", {18'h0, dt[13:0]}, 32'h3fff);
      chk("dead_time 1", {18'h0, dt[27:14]}, 32'h1234);
      chk("dead_time 2", {18'h0, dt[41:28]}, 32'h1);
      chk("enable", {31'h0, ten}, 32'h1);
      $display("register table done");
      // Fields changed by the write that clears enable, then enabled
      apb(1'b1, PTSD_OFS_CTRL, 32'h000f);
      apb(1'b1, PTSD_OFS_CTRL, 32'h800f);
      t0 = tn;
      mt(15);
      chk("ps16 a", tn - t0, 32'h0);
      mt(16);
      chk("ps16 b", tn - t0, 32'h1);
      apb(1'b0, PTSD_OFS_STAT, 32'h0);
      chk("count", q, 32'hf);
      apb(1'b1, PTSD_OFS_CTRL, 32'h0);
      apb(1'b1, PTSD_OFS_CTRL, 32'h8000);
      t0 = tn;
      mt(5);
      chk("ps1", tn - t0, 32'h5);
      apb(1'b1, PTSD_OFS_CTRL, 32'h3);
      apb(1'b1, PTSD_OFS_CTRL, 32'h8003);
      mt(3);
      apb(1'b1, PTSD_OFS_CTRL, 32'h3);
      apb(1'b1, PTSD_OFS_CTRL, 32'h8003);
      t0 = tn;
      mt(3);
      chk("ps restart a", tn - t0, 32'h0);
      mt(1);
      chk("ps restart b", tn - t0, 32'h1);
      $display("postscaler done");
      for (i = 0; i < 4; i++) begin
         apb(1'b1, PTSD_OFS_CTRL, {25'h0, sc[i], 4'h0});
         apb(1'b1, PTSD_OFS_CTRL, {16'h0, 1'b1, 8'h0, sc[i], 4'h0});
         t0 = sn;
         pins <= sp[i] ^ 3'h7;
         repeat (10) @(posedge pclk);
         chk("sync other", sn - t0, 32'h0);
         // Pins held steady well past one sync period
         pins <= 3'h7;
         repeat (10) @(posedge pclk);
         chk("sync sel", sn - t0, sx[i]);
         apb(1'b0, PTSD_OFS_STAT, 32'h0);
         chk("synced pins", q, 32'h70);
         pins <= 3'h0;
         apb(1'b1, PTSD_OFS_CTRL, 32'h0);
         repeat (10) @(posedge pclk);
      end
      $display("sync select done");
      // Reset in mid-run clears registers
      apb(1'b1, PTSD_OFS_DT0, 32'h2aaa);
      apb(1'b1, PTSD_OFS_CTRL, 32'h8025);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("reset enable", {31'h0, ten}, 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PTSD_OFS_DT0, 32'h0);
      chk("dt0 after reset", q, 32'h0);
      chk("dead_time reset", {18'h0, dt[13:0]}, 32'h0);
      apb(1'b0, PTSD_OFS_CTRL, 32'h0);
      chk("ctrl after reset", q, 32'h0);
      $display("mid-run reset done");
      stop_test;
   end
endmodule : tb_pwm_timebase_sync_trigger_deadtime
`default_nettype wire
